// [logic/etsr_pkg.sv]
// package for the edge triggered shift register block
package etsr_pkg;
  localparam int unsigned STAGES = 8;
  localparam int unsigned BYTES = 4;
  localparam int unsigned BITS_TOTAL = 32;
  localparam int unsigned SEL_W = 3;
  localparam int unsigned IDX_W = 2;
  // register map
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_DATA = 4'h8;
  // ctrl field positions
  localparam int unsigned CTRL_IDX_LSB = 0;
  localparam int unsigned CTRL_SEL_LSB = 4;
  localparam int unsigned CTRL_RET_BIT = 8;
  localparam int unsigned CTRL_LOCK_BIT = 9;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [7:0] STAGES_RESET = 8'h00;

  typedef struct packed {
    logic data;
    logic trig;
    logic dir;
    logic clr;
  } etsr_in_type;

  typedef struct packed {
    logic [IDX_W-1:0] byte_idx;
    logic [SEL_W-1:0] out_sel;
    logic retain;
  } etsr_cfg_type;
endpackage

// [logic/etsr_store.sv]
// small storage of the four stage bytes with registered read port
`timescale 1ns/10ps
module etsr_store #(
  parameter int unsigned DEPTH = 4,
  parameter int unsigned WIDTH = 8
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic clear_i,
  input wire logic we_i,
  input wire logic [$clog2(DEPTH)-1:0] waddr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  input wire logic [$clog2(DEPTH)-1:0] raddr_i,
  output logic [WIDTH-1:0] rdata_o,
  output logic [WIDTH*DEPTH-1:0] all_o
);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [WIDTH-1:0] rdata_next;

  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      mem_next[i] = mem_reg[i];
      if (clear_i) begin
        mem_next[i] = '0;
      end else if (we_i && waddr_i == i[$clog2(DEPTH)-1:0]) begin
        mem_next[i] = wdata_i;
      end
    end
    rdata_next = mem_reg[raddr_i];
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
      rdata_o <= '0;
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= mem_next[i];
      end
      rdata_o <= rdata_next;
    end
  end

  for (genvar g = 0; g < DEPTH; g++) begin : g_flat
    assign all_o[g*WIDTH +: WIDTH] = mem_reg[g];
  end
endmodule

// [logic/etsr_top.sv]
// edge triggered shift register function block with wishbone control
// Summary of operation
// - rising trigger edge samples data bit into the selected register; falling ignored
// - direction low: bit enters stage 1, stages move toward stage 8
// - direction high: bit enters stage 8, stages move toward stage 1
// - rising edge on clear input zeroes all eight stages
// - output follows one configured stage of one configured byte
// - at most 32 bits: four registers of eight stages by byte index
// - without retention, power loss clears contents; shifting restarts at entry stage
// - with retention, every stage survives power loss, never a subset
// - byte index, stage select and retention fixed once configured; the code fixes them only once CTRL_LOCK_BIT is written high
//
// Our own choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/10ps
module etsr_top (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic power_up_i,
  input wire etsr_pkg::etsr_in_type fb_in_i,
  output logic q_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  etsr_pkg::etsr_cfg_type cfg_reg;
  etsr_pkg::etsr_cfg_type cfg_next;
  etsr_pkg::etsr_cfg_type wr_cfg;
  logic lock_reg;
  logic lock_next;
  logic trig_prev_reg;
  logic trig_prev_next;
  logic clr_prev_reg;
  logic clr_prev_next;
  logic ack_reg;
  logic ack_next;
  logic [31:0] dat_reg;
  logic [31:0] dat_next;
  logic q_reg;
  logic q_next;
  logic trig_rise;
  logic clr_rise;
  logic shift_we;
  logic wipe;
  logic req;
  logic rd_req;
  logic lanes_ok;
  logic ctrl_hit;
  logic wr_ok;
  logic wr_lock;
  logic [etsr_pkg::STAGES-1:0] cur_byte;
  logic [etsr_pkg::STAGES-1:0] shift_up;
  logic [etsr_pkg::STAGES-1:0] shift_down;
  logic [etsr_pkg::STAGES-1:0] shifted;
  logic [etsr_pkg::STAGES-1:0] store_wdata;
  logic [etsr_pkg::STAGES-1:0] rd_byte;
  logic [etsr_pkg::BITS_TOTAL-1:0] all_bits;
  logic [31:0] ctrl_word;

  // previous samples reset low, the idle level of both pins, so no false edge follows reset
  always_comb begin
    trig_prev_next = fb_in_i.trig;
    clr_prev_next = fb_in_i.clr;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      trig_prev_reg <= 1'b0;
      clr_prev_reg <= 1'b0;
    end else begin
      trig_prev_reg <= trig_prev_next;
      clr_prev_reg <= clr_prev_next;
    end
  end

  // an edge is the present sample high against a low sample one clock earlier
  assign trig_rise = fb_in_i.trig & ~trig_prev_reg;
  assign clr_rise = fb_in_i.clr & ~clr_prev_reg;

  // the configured byte's eight stages out of the 32 stored bits
  assign cur_byte = all_bits[cfg_reg.byte_idx*etsr_pkg::STAGES +: etsr_pkg::STAGES];

  // bit 0 is stage 1, bit 7 is stage 8; each end stage takes the data bit
  for (genvar g = 0; g < etsr_pkg::STAGES; g++) begin : g_stage
    if (g == 0) begin : g_up_entry
      assign shift_up[g] = fb_in_i.data;
    end else begin : g_up_move
      assign shift_up[g] = cur_byte[g-1];
    end
    if (g == etsr_pkg::STAGES-1) begin : g_down_entry
      assign shift_down[g] = fb_in_i.data;
    end else begin : g_down_move
      assign shift_down[g] = cur_byte[g+1];
    end
  end

  always_comb begin
    if (fb_in_i.dir) begin
      shifted = shift_down;
    end else begin
      shifted = shift_up;
    end
    // a clear that meets a trigger writes zeros, so the clear wins
    if (clr_rise) begin
      store_wdata = etsr_pkg::STAGES_RESET;
    end else begin
      store_wdata = shifted;
    end
  end

  // the clear reaches only the configured byte; the other bytes stay independent
  assign shift_we = trig_rise | clr_rise;
  // power_up_i models a power return; a retentive block keeps all 32 bits, never a subset
  assign wipe = power_up_i & ~cfg_reg.retain;

  // power wipe has priority inside the store over the shift write
  etsr_store #(
    .DEPTH(etsr_pkg::BYTES),
    .WIDTH(etsr_pkg::STAGES)
  ) u_store (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .clear_i(wipe),
    .we_i(shift_we),
    .waddr_i(cfg_reg.byte_idx),
    .wdata_i(store_wdata),
    .raddr_i(cfg_reg.byte_idx),
    .rdata_o(rd_byte),
    .all_o(all_bits)
  );

  // a request is taken at an edge with cyc and stb high and no ack standing
  assign req = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign rd_req = req & ~wb_we_i;
  assign ctrl_hit = wb_adr_i == etsr_pkg::ADDR_CTRL;
  // a write missing either low lane is refused whole, so no setting is half applied
  assign lanes_ok = wb_sel_i[0] & wb_sel_i[1];
  // configuration is frozen once locked: it cannot change while the program runs
  assign wr_ok = req & wb_we_i & ctrl_hit & lanes_ok & ~lock_reg;

  // control word fields as written
  always_comb begin
    wr_cfg.byte_idx = wb_dat_i[etsr_pkg::CTRL_IDX_LSB +: etsr_pkg::IDX_W];
    wr_cfg.out_sel = wb_dat_i[etsr_pkg::CTRL_SEL_LSB +: etsr_pkg::SEL_W];
    wr_cfg.retain = wb_dat_i[etsr_pkg::CTRL_RET_BIT];
    wr_lock = wb_dat_i[etsr_pkg::CTRL_LOCK_BIT];
  end

  always_comb begin
    cfg_next = cfg_reg;
    lock_next = lock_reg;
    if (wr_ok) begin
      cfg_next = wr_cfg;
      lock_next = wr_lock;
    end
  end

  // lock is sticky: only reset opens the configuration again
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_reg <= '0;
      lock_reg <= 1'b0;
    end else begin
      cfg_reg <= cfg_next;
      lock_reg <= lock_next;
    end
  end

  // readback image of the control word
  always_comb begin
    ctrl_word = etsr_pkg::CTRL_RESET;
    ctrl_word[etsr_pkg::CTRL_IDX_LSB +: etsr_pkg::IDX_W] = cfg_reg.byte_idx;
    ctrl_word[etsr_pkg::CTRL_SEL_LSB +: etsr_pkg::SEL_W] = cfg_reg.out_sel;
    ctrl_word[etsr_pkg::CTRL_RET_BIT] = cfg_reg.retain;
    ctrl_word[etsr_pkg::CTRL_LOCK_BIT] = lock_reg;
  end

  // reads are answered one clock after the request; the stage byte comes from the
  // store's registered port and so lags a shift by one clock
  always_comb begin
    ack_next = req;
    dat_next = dat_reg;
    if (rd_req) begin
      unique case (wb_adr_i)
        etsr_pkg::ADDR_CTRL: dat_next = ctrl_word;
        etsr_pkg::ADDR_STATUS: dat_next = {24'h000000, rd_byte};
        etsr_pkg::ADDR_DATA: dat_next = all_bits;
        default: dat_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_reg <= 1'b0;
      dat_reg <= etsr_pkg::CTRL_RESET;
    end else begin
      ack_reg <= ack_next;
      dat_reg <= dat_next;
    end
  end

  // q follows its stage through a flop, two clocks behind the trigger edge
  always_comb begin
    q_next = cur_byte[cfg_reg.out_sel];
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_reg <= 1'b0;
    end else begin
      q_reg <= q_next;
    end
  end

  assign q_o = q_reg;
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
endmodule

// [tb/etsr_bench.sv]
// self-checking bench of etsr_top
`timescale 1ns/10ps
module etsr_bench;
  logic clk = 0, rst_n = 0, pwr = 0, cyc = 0, stb = 0, we = 0, ack, q, d, r;
  logic [3:0] adr = 4'h0, sel = 4'hF;
  logic [31:0] wd = 32'h0, rd, dat, m = 32'h0;
  etsr_pkg::etsr_in_type fb;
  int errors = 0, tests_run = 0, s;
  always #50 clk = ~clk;
  etsr_top dut_u (.core_clk_i(clk), .rst_n_i(rst_n), .power_up_i(pwr), .fb_in_i(fb),
    .q_o(q), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wd), .wb_dat_o(dat), .wb_ack_o(ack));
  etsr_partner p_u (.core_clk_i(clk), .fb_o(fb));
  function automatic logic [7:0] sh(logic [7:0] v, logic b, logic dr);
    return dr ? {b, v[7:1]} : {v[6:0], b};
  endfunction
  task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s exp %h seen %h", n, exp, seen);
    end
  endtask
  task automatic bus(logic w, logic [3:0] a, logic [31:0] v);
    {cyc, stb, we, adr, wd} <= {2'h3, w, a, v};
    do @(posedge clk); while (ack !== 1'b1);
    rd = dat;
    {cyc, stb} <= 2'h0;
    @(posedge clk);
    chk("ack", ack, 0);
  endtask
  task automatic pow;
    pwr <= 1;
    @(posedge clk);
    pwr <= 0;
    @(posedge clk);
  endtask
  task automatic print_verdict;
    $display("errors %0d checks %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    void'($urandom(32'hF312D2F4));
    repeat (20) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    for (int b = 0; b < 4; b++) begin
      s = $urandom % 8;
      bus(1, 4'h0, 32'(b) | 32'(s << 4));
      repeat (10) begin
        d = 1'($urandom);
        r = 1'($urandom);
        p_u.pulse(d, r, 0);
        m[b*8 +: 8] = sh(m[b*8 +: 8], d, r);
      end
      chk("q", q, m[b*8+s]);
      bus(0, 4'h8, 0);
      chk("data", rd, m);
    end
    p_u.pulse(1, 0, 1);
    bus(0, 4'h4, 0);
    chk("status", rd, 0);
    m[31:24] = 8'h00;
    bus(0, 4'h8, 0);
    chk("cleared", rd, m);
    pow();
    bus(0, 4'h8, 0);
    chk("wiped", rd, 0);
    sel <= 4'h1;
    bus(1, 4'h0, 32'h0000_0001);
    sel <= 4'hF;
    bus(0, 4'h0, 0);
    chk("lanes", rd, 32'(3) | 32'(s << 4));
    bus(1, 4'h0, 32'h0000_0303);
    p_u.pulse(1, 1, 0);
    pow();
    bus(0, 4'h8, 0);
    chk("kept", rd, 32'h8000_0000);
    bus(1, 4'h0, 32'h0);
    bus(0, 4'h0, 0);
    chk("ctrl", rd, 32'h0000_0303);
    bus(0, 4'h4, 0);
    chk("locked", rd, 32'h80);
    bus(0, 4'hC, 0);
    chk("unmapped", rd, 0);
    print_verdict();
  end
  // whole run is a few hundred cycles
  initial begin
    #2_000_000;
    errors++;
    print_verdict();
  end
endmodule

// [tb/etsr_partner.sv]
// far-side logic driving the block inputs
`timescale 1ns/10ps
module etsr_partner (
  input wire logic core_clk_i,
  output etsr_pkg::etsr_in_type fb_o
);
  initial fb_o = '0;
  // trigger two samples high, two low, so each rise stands alone
  task automatic pulse(logic d, logic dr, logic c);
    fb_o <= '{d, 1'b1, dr, c};
    repeat (2) @(posedge core_clk_i);
    fb_o <= '{~d, 1'b0, dr, 1'b0}; // data released: inverse shown
    repeat (2) @(posedge core_clk_i);
  endtask
endmodule

// [tb/etsr_top_asserts.sv]
// port checker for etsr_top
`timescale 1ns/10ps
module etsr_asserts (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic power_up_i,
  input wire etsr_pkg::etsr_in_type fb_in_i,
  input wire logic q_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_ack_resp; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("ack late");
  property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack uncalled");
  property p_idle; !wb_cyc_i |=> !wb_ack_o; endproperty
  a_idle: assert property (p_idle) else $error("ack while idle");
  property p_unmapped; wb_ack_o && !wb_we_i && !(wb_adr_i inside {4'h0, 4'h4, 4'h8})
    |-> wb_dat_o == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
  property p_dat_hold; !(wb_ack_o && !wb_we_i) |-> $stable(wb_dat_o); endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("read data moved");
  property p_clr; $rose(fb_in_i.clr) |-> ##[2:3] !q_o; endproperty
  a_clr: assert property (p_clr) else $error("q set after clear");
  // three quiet samples cover the two-edge output latency
  property p_q_hold; (!fb_in_i.trig && !fb_in_i.clr && !wb_cyc_i && !power_up_i)[*3]
    |=> $stable(q_o); endproperty
  a_q_hold: assert property (p_q_hold) else $error("q moved without cause");
  c_clr: cover property ($rose(fb_in_i.clr));
  c_trig: cover property ($rose(fb_in_i.trig) && !fb_in_i.clr);
  c_read: cover property (wb_ack_o && !wb_we_i);
endmodule
bind etsr_top etsr_asserts chk_u (.*);
